// file: shared/svis_defines.svh
/*
 * Offsets, field positions, reset values and group masks for the shared-vector
 * interrupt source block.
 * Assumes it is included once per compilation unit; the guard protects against repeats.
 */
// Operation
// RULE1 - Set the nonvolatile request flag when a data-memory write completes.
// RULE2 - Vector nonvolatile source only with global, source, group enables and stack room.
// RULE3 - Nonvolatile service clears global enable and group flag, not the source flag.
// RULE4 - Set the supply-drop flag while the detector reports low supply.
// RULE5 - Vector supply-drop source only with global, source, group enables and stack room.
// RULE6 - Supply-drop service clears global enable and group flag only.
// RULE7 - Each timer unit has compare A and compare P flags, each with an enable.
// RULE8 - A timer request rises whenever a compare A or P match sets a flag.
// RULE9 - Timer match vectors only with global, source, group enables and stack room.
// RULE10 - Timer service clears global enable and its group flag; software clears matches.
// RULE11 - Any request flag rising wakes the halted core, whatever the enables.
// RULE12 - Software pre-sets a flag before halting to mask that source's wake-up.
// RULE13 - A set flag stays set while disabled until serviced or cleared.
// RULE14 - Entry pushes only the program counter; the handler saves other state.
// RULE15 - Interrupt return sets global enable; plain return leaves it clear.
// RULE16 - A group flag sets whenever any of its member sources sets its flag.
// RULE17 - A pending call waits for instruction end, then is presented for one cycle.
`ifndef SVIS_DEFINES_SVH
`define SVIS_DEFINES_SVH

// Register byte offsets on the APB bus.
`define SVIS_CTRL_OFS 12'h000
`define SVIS_SRC_EN_OFS 12'h004
`define SVIS_SRC_FLAG_OFS 12'h008
`define SVIS_SRC_SET_OFS 12'h00c
`define SVIS_SV_FLAG_OFS 12'h010
`define SVIS_STATUS_OFS 12'h014

// Control register fields.
`define SVIS_CTRL_GIE_BIT 0
`define SVIS_CTRL_SVE_LSB 1

// Source bit positions, shared by enable, flag and set registers.
`define SVIS_SRC_NVM 0
`define SVIS_SRC_SUP 1
`define SVIS_SRC_T0A 2
`define SVIS_SRC_T0P 3
`define SVIS_SRC_T1A 4
`define SVIS_SRC_T1P 5

// Counts and group membership of the sources.
`define SVIS_NUM_SRC 6
`define SVIS_NUM_SV 3
`define SVIS_GROUP0_MASK 6'h0c
`define SVIS_GROUP1_MASK 6'h30
`define SVIS_GROUP2_MASK 6'h03

// Reset values.
`define SVIS_SRC_RESET 6'h00
`define SVIS_SV_RESET 3'h0

`endif

// file: shared/svis_pkg.sv
/*
 * Types for the shared-vector interrupt source block.
 * Assumes the defines header is available on the include path.
 */
`default_nettype none
package svis_pkg;
    // Sequencing of a vector call toward the core.
    typedef enum logic [0:0] {
        SVIS_IDLE,
        SVIS_PENDING
    } svis_state_type;
endpackage : svis_pkg
`default_nettype wire

// file: design/svis_shared_vector_irq.sv
/*
 * Shared-vector interrupt sources: source flags, group flags, vector call
 * sequencing, wake-up detection and an APB register slave.
 * Assumes a core sequencer on pclk that pulses instr_done at the end of each
 * instruction and pulses the two return strobes; the supply-drop detector is
 * asynchronous, all other sources are single-cycle pulses on pclk.
 */
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "svis_defines.svh"
`default_nettype none
module svis_shared_vector_irq
    import svis_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nvm_write_done,
    input wire logic supply_drop_detector,
    input wire logic [1:0] compare_a_match,
    input wire logic [1:0] compare_p_match,
    input wire logic instr_done,
    input wire logic stack_full,
    input wire logic core_halted,
    input wire logic return_with_irq_enable,
    input wire logic plain_return,
    output logic vector_call,
    output logic [1:0] vector_index,
    output logic push_pc_only,
    output logic wake_up,
    output logic global_irq_enable
);

    // Source flags, enables and group state.
    logic [5:0] src_flag;
    logic [5:0] src_en;
    logic [2:0] shared_vector_flag;
    logic [2:0] shared_vector_enable;
    logic [5:0] next_src_flag;
    logic [2:0] next_sv_flag;
    logic [5:0] src_set;
    logic [5:0] src_rise;
    logic [2:0] sv_set;
    logic [2:0] sv_ready;
    logic [5:0] group_mask [0:2];
    logic [2:0] sup_sync;
    logic sup_low;
    svis_state_type state;
    logic [1:0] pend_index;
    logic service;
    logic req_any;
    logic [1:0] req_index;

    // APB decode: a transfer commits at the edge where pready is seen high.
    logic apb_commit;
    logic wr_commit;
    logic [31:0] next_rdata;
    logic addr_ok;

    assign apb_commit = psel & penable & pready;
    assign wr_commit = apb_commit & pwrite;

    assign group_mask[0] = `SVIS_GROUP0_MASK;
    assign group_mask[1] = `SVIS_GROUP1_MASK;
    assign group_mask[2] = `SVIS_GROUP2_MASK;

    // The detector is asynchronous, so it passes three flops and counts
    // only when the last two agree, which rejects a half-settled sample.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sup_sync <= 3'h0;
            sup_low <= 1'b0;
        end
        else
        begin
            sup_sync <= {sup_sync[1:0], supply_drop_detector};
            if (sup_sync[1] == sup_sync[2])
            begin
                sup_low <= sup_sync[2];
            end
        end
    end

    // Hardware and software set events; the supply-drop flag is refreshed for as long
    // as the low condition lasts.
    always_comb
    begin
        src_set = 6'h00;
        src_set[`SVIS_SRC_NVM] = nvm_write_done; // RULE1
        src_set[`SVIS_SRC_SUP] = sup_low; // RULE4
        src_set[`SVIS_SRC_T0A] = compare_a_match[0]; // RULE7
        src_set[`SVIS_SRC_T0P] = compare_p_match[0]; // RULE8
        src_set[`SVIS_SRC_T1A] = compare_a_match[1]; // RULE7
        src_set[`SVIS_SRC_T1P] = compare_p_match[1]; // RULE8
        if (wr_commit && paddr == `SVIS_SRC_SET_OFS)
        begin
            src_set = src_set | pwdata[5:0]; // RULE12
        end
    end

    // Source flags clear only by a software write of one; service never
    // touches them, and a set in the same cycle beats the clear.
    always_comb
    begin
        next_src_flag = src_flag; // RULE13
        if (wr_commit && paddr == `SVIS_SRC_FLAG_OFS)
        begin
            next_src_flag = next_src_flag & ~pwdata[5:0]; // RULE10
        end
        next_src_flag = next_src_flag | src_set;
    end

    assign src_rise = next_src_flag & ~src_flag;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_flag <= `SVIS_SRC_RESET;
        end
        else
        begin
            src_flag <= next_src_flag; // RULE3 RULE6
        end
    end

    // Per-group flag set and readiness; one copy per shared vector.
    genvar g;
    generate
        for (g = 0; g < `SVIS_NUM_SV; g = g + 1)
        begin : gen_group
            assign sv_set[g] = |(src_rise & group_mask[g]); // RULE16
            // A group may call only if a member is both flagged and enabled.
            assign sv_ready[g] = shared_vector_flag[g] & shared_vector_enable[g] &
                |(src_flag & src_en & group_mask[g]); // RULE2 RULE5 RULE9
        end
    endgenerate

    // Lowest group index wins when several are ready.
    always_comb
    begin
        req_index = 2'h0;
        if (sv_ready[0])
        begin
            req_index = 2'h0;
        end
        else if (sv_ready[1])
        begin
            req_index = 2'h1;
        end
        else
        begin
            req_index = 2'h2;
        end
    end

    assign req_any = global_irq_enable & ~stack_full & (|sv_ready); // RULE2 RULE5 RULE9

    // The call fires at instruction end if the latched group still qualifies.
    assign service = (state == SVIS_PENDING) & instr_done & global_irq_enable &
        ~stack_full & sv_ready[pend_index]; // RULE17

    // Pending request sequencing; a request that lapses before the
    // instruction ends is dropped and re-evaluated afresh.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= SVIS_IDLE;
            pend_index <= 2'h0;
        end
        else
        begin
            unique case (state)
                SVIS_IDLE:
                begin
                    if (req_any)
                    begin
                        state <= SVIS_PENDING;
                        pend_index <= req_index;
                    end
                end
                SVIS_PENDING:
                begin
                    if (instr_done)
                    begin
                        state <= SVIS_IDLE; // RULE17
                    end
                end
            endcase
        end
    end

    // Call strobes toward the core, one cycle each.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vector_call <= 1'b0;
            vector_index <= 2'h0;
            push_pc_only <= 1'b0;
        end
        else
        begin
            vector_call <= service; // RULE17
            push_pc_only <= service; // RULE14
            if (service)
            begin
                vector_index <= pend_index;
            end
        end
    end

    // Group flags: service clears the one taken, software may clear by
    // writing one, and a new member event wins over both.
    always_comb
    begin
        next_sv_flag = shared_vector_flag;
        if (service)
        begin
            next_sv_flag[pend_index] = 1'b0; // RULE3 RULE6 RULE10
        end
        if (wr_commit && paddr == `SVIS_SV_FLAG_OFS)
        begin
            next_sv_flag = next_sv_flag & ~pwdata[2:0];
        end
        next_sv_flag = next_sv_flag | sv_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shared_vector_flag <= `SVIS_SV_RESET;
        end
        else
        begin
            shared_vector_flag <= next_sv_flag;
        end
    end

    // Global enable: service clears it, a software write sets either way, a plain
    // return in the same cycle undoes that write, and the interrupt return sets it last so it wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            global_irq_enable <= 1'b0;
        end
        else
        begin
            if (service)
            begin
                global_irq_enable <= 1'b0; // RULE3 RULE6 RULE10
            end
            if (wr_commit && paddr == `SVIS_CTRL_OFS)
            begin
                global_irq_enable <= pwdata[`SVIS_CTRL_GIE_BIT];
            end
            if (return_with_irq_enable)
            begin
                global_irq_enable <= 1'b1; // RULE15
            end
            else if (plain_return)
            begin
                global_irq_enable <= global_irq_enable & ~service; // RULE15
            end
        end
    end

    // Enable registers written by software.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shared_vector_enable <= 3'h0;
            src_en <= 6'h00;
        end
        else if (wr_commit)
        begin
            if (paddr == `SVIS_CTRL_OFS)
            begin
                shared_vector_enable <= pwdata[`SVIS_CTRL_SVE_LSB +: 3];
            end
            if (paddr == `SVIS_SRC_EN_OFS)
            begin
                src_en <= pwdata[5:0]; // RULE7
            end
        end
    end

    // Wake-up looks only at flag rises, never at enables, so that a
    // pre-set flag cannot wake the core again.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_up <= 1'b0;
        end
        else
        begin
            wake_up <= core_halted & ((|src_rise) | (|sv_set)); // RULE11 RULE12
        end
    end

    // Read mux; unused bits read as zero.
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        addr_ok = 1'b1;
        unique case (paddr)
            `SVIS_CTRL_OFS: next_rdata[3:0] = {shared_vector_enable, global_irq_enable};
            `SVIS_SRC_EN_OFS: next_rdata[5:0] = src_en;
            `SVIS_SRC_FLAG_OFS: next_rdata[5:0] = src_flag;
            `SVIS_SRC_SET_OFS: next_rdata = 32'h0000_0000;
            `SVIS_SV_FLAG_OFS: next_rdata[2:0] = shared_vector_flag;
            `SVIS_STATUS_OFS: next_rdata[1:0] = {sup_low, state == SVIS_PENDING};
            default: addr_ok = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle, so every
    // answer comes from a flop at the cost of a slower bus.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok;
            if (psel && penable && !pready && !pwrite)
            begin
                prdata <= next_rdata;
            end
            else if (apb_commit)
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule // svis_shared_vector_irq
`default_nettype wire

// file: test/svis_checker.sv
/* Checker for the shared-vector interrupt block: call, return and APB timing.
   Assumes it is bound to the block's top module and sees its ports only. */
`default_nettype none
module svis_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic instr_done,
    input wire logic stack_full,
    input wire logic core_halted,
    input wire logic return_with_irq_enable,
    input wire logic plain_return,
    input wire logic vector_call,
    input wire logic push_pc_only,
    input wire logic wake_up,
    input wire logic global_irq_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A register write may set the enable again, so calls next to one are excused.
    property p_call_pulse; vector_call |=> !vector_call; endproperty
    a_call_pulse: assert property (p_call_pulse) else $error("call too long");
    property p_push_pc; vector_call == push_pc_only; endproperty
    a_push_pc: assert property (p_push_pc) else $error("push differs");
    property p_call_instr; $rose(vector_call) |-> $past(instr_done); endproperty
    a_call_instr: assert property (p_call_instr) else $error("call mid-instr");
    property p_call_ok; $rose(vector_call) |-> $past(global_irq_enable && !stack_full); endproperty
    a_call_ok: assert property (p_call_ok) else $error("call unqualified");
    property p_call_gie;
        vector_call && !$past(return_with_irq_enable) && !$past(psel && pwrite)
            |-> !global_irq_enable;
    endproperty
    a_call_gie: assert property (p_call_gie) else $error("gie kept");
    property p_return_with_irq_enable; return_with_irq_enable |=> global_irq_enable; endproperty
    a_return_with_irq_enable: assert property (p_return_with_irq_enable) else $error("return_with_irq_enable no gie");
    property p_ret;
        plain_return && !global_irq_enable && !return_with_irq_enable && !(psel && pwrite)
            |=> !global_irq_enable;
    endproperty
    a_ret: assert property (p_ret) else $error("ret set gie");
    property p_wake; wake_up |-> $past(core_halted); endproperty
    a_wake: assert property (p_wake) else $error("wake not halted");
    property p_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
    a_wait: assert property (p_wait) else $error("apb wait wrong");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    c_call: cover property (vector_call);
    c_wake: cover property (wake_up);
    c_err: cover property (pslverr);
endmodule // svis_checker
bind svis_shared_vector_irq svis_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .pready, .pslverr, .instr_done, .stack_full, .core_halted, .return_with_irq_enable,
    .plain_return, .vector_call, .push_pc_only, .wake_up, .global_irq_enable);
`default_nettype wire

// file: test/svis_core_model.sv
/* Model of the core sequencer and its return stack.
   Assumes the bench requests halts and returns one cycle at a time. */
`default_nettype none
module svis_core_model #(
    parameter int STACK_DEPTH = 1,
    parameter int INSTR_GAP = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic vector_call,
    input wire logic push_pc_only,
    input wire logic halt_req,
    input wire logic return_with_irq_enable_req,
    input wire logic ret_req,
    output logic instr_done,
    output logic stack_full,
    output logic core_halted,
    output logic return_with_irq_enable,
    output logic plain_return
);
    int depth;
    int gap;
    // Only the program counter is pushed; a handler must save anything else itself.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            depth <= 0;
            gap <= 0;
            instr_done <= 1'b0;
            core_halted <= 1'b0;
            return_with_irq_enable <= 1'b0;
            plain_return <= 1'b0;
        end
        else
        begin
            gap <= (gap == INSTR_GAP - 1) ? 0 : gap + 1;
            instr_done <= (gap == INSTR_GAP - 1) && !halt_req;
            core_halted <= halt_req;
            return_with_irq_enable <= return_with_irq_enable_req && depth > 0;
            plain_return <= ret_req && depth > 0;
            if (vector_call && push_pc_only)
                depth <= depth + 1;
            else if ((return_with_irq_enable_req || ret_req) && depth > 0)
                depth <= depth - 1;
        end
    end
    // A full stack refuses further calls until a return pops it.
    assign stack_full = depth >= STACK_DEPTH;
endmodule // svis_core_model
`default_nettype wire

// file: test/svis_shared_vector_irq_tb.sv
/* Self-checking bench for the shared-vector interrupt block.
   Assumes the core model and the checker are compiled alongside. */
`include "svis_defines.svh"
`default_nettype none
module svis_shared_vector_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [5:0] src_hit = 6'h00;
    logic halt_req = 1'b0;
    logic return_with_irq_enable_req = 1'b0;
    logic ret_req = 1'b0;
    logic pready, pslverr, instr_done, stack_full, core_halted, return_with_irq_enable;
    logic plain_return, vector_call, push_pc_only, wake_up, global_irq_enable, er;
    logic [1:0] vector_index;
    logic [31:0] prdata, rd;
    int fails = 0;
    int samples_checked = 0;
    int calls = 0;
    int wakes = 0;
    int base;

    always #2 pclk = ~pclk;

    svis_shared_vector_irq uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .nvm_write_done(src_hit[0]),
        .supply_drop_detector(src_hit[1]), .compare_a_match({src_hit[4], src_hit[2]}),
        .compare_p_match({src_hit[5], src_hit[3]}), .instr_done, .stack_full, .core_halted,
        .return_with_irq_enable, .plain_return, .vector_call, .vector_index, .push_pc_only,
        .wake_up, .global_irq_enable);
    svis_core_model #(.STACK_DEPTH(1), .INSTR_GAP(3)) core (.pclk, .presetn, .vector_call,
        .push_pc_only, .halt_req, .return_with_irq_enable_req, .ret_req, .instr_done, .stack_full, .core_halted,
        .return_with_irq_enable, .plain_return);

    // Calls and wake-ups are single-cycle pulses, so they are counted as they pass.
    always @(posedge pclk)
    begin
        calls <= calls + ((vector_call === 1'b1) ? 1 : 0);
        wakes <= wakes + ((wake_up === 1'b1) ? 1 : 0);
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pready is looked at on the rising edge itself, before that edge's updates land,
    // so the request is held until the very edge at which the slave answers.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task pulse(input int i);
        @(posedge pclk);
        src_hit[i] <= 1'b1;
        repeat ((i == 1) ? 2 : 1) @(posedge pclk);
        src_hit[i] <= 1'b0;
    endtask

    task core_req(input logic irq);
        @(posedge pclk);
        if (irq) return_with_irq_enable_req <= 1'b1;
        else ret_req <= 1'b1;
        @(posedge pclk);
        return_with_irq_enable_req <= 1'b0;
        ret_req <= 1'b0;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask

    task wait_calls(input int n);
        for (int k = 0; k < 60 && calls != n; k++) @(posedge pclk);
        @(negedge pclk);
    endtask

    task t_reset_map;
        apb(0, `SVIS_CTRL_OFS, 0);
        chk(rd, 0);
        apb(0, `SVIS_SRC_EN_OFS, 0);
        chk(rd, 0);
        apb(0, `SVIS_SRC_FLAG_OFS, 0);
        chk(rd, 0);
        apb(0, `SVIS_STATUS_OFS, 0);
        chk(rd, 0);
        apb(0, `SVIS_SV_FLAG_OFS, 0);
        chk(rd, 0);
        apb(0, 12'h100, 32'hffff);
        chk({31'h0, er}, 1);
        chk(rd, 0);
    endtask

    task t_each_source;
        for (int i = 0; i < 6; i++)
        begin
            base = calls;
            apb(1, `SVIS_CTRL_OFS, 32'h0f);
            apb(1, `SVIS_SRC_EN_OFS, 32'h1 << i);
            pulse(i);
            wait_calls(base + 1);
            chk(calls, base + 1);
            chk({30'h0, vector_index}, (i < 2) ? 2 : (i - 2) / 2);
            chk({31'h0, global_irq_enable}, 0);
            apb(0, `SVIS_SV_FLAG_OFS, 0);
            chk(rd, 0);
            apb(0, `SVIS_SRC_FLAG_OFS, 0);
            chk(rd, 32'h1 << i);
            apb(1, `SVIS_SRC_FLAG_OFS, 32'h1 << i);
            core_req(1'b1);
            chk({31'h0, global_irq_enable}, 1);
        end
    endtask

    task t_stack_plain;
        base = calls;
        apb(1, `SVIS_SRC_EN_OFS, 32'h3f);
        pulse(2);
        wait_calls(base + 1);
        apb(1, `SVIS_SRC_FLAG_OFS, 32'h04);
        apb(1, `SVIS_CTRL_OFS, 32'h0f);
        pulse(4);
        wait_calls(base + 2);
        chk(calls, base + 1);
        apb(0, `SVIS_SV_FLAG_OFS, 0);
        chk(rd, 32'h2);
        core_req(1'b0);
        wait_calls(base + 2);
        chk(calls, base + 2);
        chk({30'h0, vector_index}, 1);
        apb(1, `SVIS_SRC_FLAG_OFS, 32'h10);
        core_req(1'b0);
        chk({31'h0, global_irq_enable}, 0);
    endtask

    task t_masked;
        base = calls;
        apb(1, `SVIS_CTRL_OFS, 32'h0f);
        apb(1, `SVIS_SRC_EN_OFS, 32'h00);
        pulse(5);
        wait_calls(base + 1);
        chk(calls, base);
        apb(0, `SVIS_SRC_FLAG_OFS, 0);
        chk(rd, 32'h20);
        apb(1, `SVIS_SRC_EN_OFS, 32'h20);
        wait_calls(base + 1);
        chk(calls, base + 1);
        apb(1, `SVIS_SRC_FLAG_OFS, 32'h20);
        core_req(1'b1);
    endtask

    task t_wake;
        base = wakes;
        apb(1, `SVIS_CTRL_OFS, 32'h00);
        apb(1, `SVIS_SRC_SET_OFS, 32'h01);
        @(posedge pclk);
        halt_req <= 1'b1;
        repeat (4) @(posedge pclk);
        pulse(0);
        repeat (6) @(negedge pclk);
        chk(wakes, base);
        pulse(3);
        repeat (6) @(negedge pclk);
        chk(wakes, base + 1);
        @(posedge pclk);
        halt_req <= 1'b0;
        apb(1, `SVIS_SRC_FLAG_OFS, 32'h3f);
        apb(1, `SVIS_SV_FLAG_OFS, 32'h07);
        apb(0, `SVIS_SV_FLAG_OFS, 0);
        chk(rd, 0);
        apb(0, `SVIS_SRC_FLAG_OFS, 0);
        chk(rd, 0);
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_map;
        t_each_source;
        t_stack_plain;
        t_masked;
        t_wake;
        conclude;
    end

    // The whole run needs a few hundred cycles, so this limit only cuts a hang.
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        conclude;
    end
endmodule // svis_shared_vector_irq_tb
`default_nettype wire
